//--- include/urs_map.vh
// register offsets, field positions and reset values of the uart register select block
`ifndef URS_MAP_VH
`define URS_MAP_VH

// ==================================================================
// address offsets
`define URS_OFF_HOLDING      3'h0
`define URS_OFF_IRQ_ENABLE   3'h1
`define URS_OFF_IRQ_FIFO     3'h2
`define URS_OFF_LINE_CTRL    3'h3
`define URS_OFF_MODEM_CTRL   3'h4
`define URS_OFF_LINE_STATUS  3'h5
`define URS_OFF_MODEM_STATUS 3'h6
`define URS_OFF_SCRATCH      3'h7

// ==================================================================
// gating values and field positions
`define URS_ENH_ACCESS_KEY   8'hbf
`define URS_LCR_DIV_EN_BIT   7
`define URS_EFR_ENH_BIT      4
`define URS_MCR_RDY_EN_BIT   2
`define URS_MCR_LOOP_BIT     4
`define URS_MCR_THR_EN_BIT   6
`define URS_FCR_EN_BIT       0
`define URS_FCR_RXRST_BIT    1
`define URS_FCR_TXRST_BIT    2

// masks of the bits locked behind the enhanced-function enable
`define URS_IER_ENH_MASK     8'hf0
`define URS_FCR_ENH_MASK     8'h30
`define URS_IIR_ENH_MASK     8'h30
`define URS_MCR_ENH_MASK     8'he0
// fifo reset bits are pulses and are never stored
`define URS_FCR_STORE_MASK   8'hf9
// fifo ready summary: tx ready in bits 1:0, rx ready in bits 5:4
`define URS_RDY_TX_LSB       0
`define URS_RDY_RX_LSB       4

// ==================================================================
// reset values
`define URS_RST_BYTE         8'h00
`define URS_RST_DIVISOR      16'h0000

`endif

//--- hw/urs_register_select.v
// host register decode and register bank for one channel of a dual uart
`timescale 1ns/10ps
`include "urs_map.vh"

module urs_register_select #(
  parameter CHANNEL_B = 0
) (
  CLK,
  RESET,
  CHAN_A_SEL_N,
  CHAN_B_SEL_N,
  ADDR,
  IOR_N,
  IOW_N,
  D_IN,
  D_OUT,
  D_OE,
  RX_DATA,
  LINE_STATUS_IN,
  IRQ_CODE_IN,
  MODEM_IN,
  TX_READY_IN,
  RX_READY_IN,
  TX_DATA,
  TX_WRITE,
  RX_READ,
  RX_FIFO_RESET,
  TX_FIFO_RESET,
  DIVISOR,
  IRQ_ENABLE,
  FIFO_CONTROL,
  LINE_CONTROL,
  MODEM_CONTROL,
  ENH_FEATURES,
  RESUME_CHAR_1,
  RESUME_CHAR_2,
  PAUSE_CHAR_1,
  PAUSE_CHAR_2,
  FLOW_THRESHOLDS,
  TRIGGER_LEVELS
);

  // ==================================================================
  // ports
  input  wire        CLK;
  input  wire        RESET;
  input  wire        CHAN_A_SEL_N;
  input  wire        CHAN_B_SEL_N;
  input  wire [2:0]  ADDR;
  input  wire        IOR_N;
  input  wire        IOW_N;
  input  wire [7:0]  D_IN;
  output wire [7:0]  D_OUT;
  output wire        D_OE;
  input  wire [7:0]  RX_DATA;
  input  wire [7:0]  LINE_STATUS_IN;
  input  wire [5:0]  IRQ_CODE_IN;
  input  wire [3:0]  MODEM_IN;
  input  wire [1:0]  TX_READY_IN;
  input  wire [1:0]  RX_READY_IN;
  output wire [7:0]  TX_DATA;
  output wire        TX_WRITE;
  output wire        RX_READ;
  output wire        RX_FIFO_RESET;
  output wire        TX_FIFO_RESET;
  output wire [15:0] DIVISOR;
  output wire [7:0]  IRQ_ENABLE;
  output wire [7:0]  FIFO_CONTROL;
  output wire [7:0]  LINE_CONTROL;
  output wire [7:0]  MODEM_CONTROL;
  output wire [7:0]  ENH_FEATURES;
  output wire [7:0]  RESUME_CHAR_1;
  output wire [7:0]  RESUME_CHAR_2;
  output wire [7:0]  PAUSE_CHAR_1;
  output wire [7:0]  PAUSE_CHAR_2;
  output wire [7:0]  FLOW_THRESHOLDS;
  output wire [7:0]  TRIGGER_LEVELS;

  // ==================================================================
  // storage
  reg  [7:0]  divisor_low_ff;
  reg  [7:0]  divisor_high_ff;
  reg  [7:0]  irq_enable_ff;
  reg  [7:0]  fifo_control_ff;
  reg  [7:0]  line_control_ff;
  reg  [7:0]  modem_control_ff;
  reg  [7:0]  enh_features_ff;
  reg  [7:0]  resume_1_ff;
  reg  [7:0]  resume_2_ff;
  reg  [7:0]  pause_1_ff;
  reg  [7:0]  pause_2_ff;
  reg  [7:0]  flow_thresh_ff;
  reg  [7:0]  trigger_lvl_ff;
  reg  [7:0]  scratch_ff;
  reg  [7:0]  tx_data_ff;
  reg         tx_write_ff;
  reg         rx_read_ff;
  reg         rx_rst_ff;
  reg         tx_rst_ff;
  reg  [7:0]  d_out_ff;
  reg         d_oe_ff;
  reg         ior_n_ff;
  reg         iow_n_ff;
  reg  [3:0]  modem_prev_ff;
  reg  [3:0]  modem_delta_ff;

  reg  [3:0]  nxt_modem_delta;
  reg  [7:0]  rd_data;

  // ==================================================================
  // gating terms
  wire        own_sel_n;
  wire        sel;
  wire        rd_start;
  wire        wr_start;
  wire        div_en;
  wire        enh_key;
  wire        enh_on;
  wire        thr_en;
  wire        rdy_en;
  wire [7:0]  rdy_summary;
  wire [7:0]  irq_id;
  wire [7:0]  modem_status;
  wire [3:0]  modem_change;

  assign own_sel_n = (CHANNEL_B != 0) ? CHAN_B_SEL_N : CHAN_A_SEL_N;
  assign sel       = ~own_sel_n;
  // one access per strobe: act on the first low cycle only
  assign rd_start  = sel & ~IOR_N & ior_n_ff;
  assign wr_start  = sel & ~IOW_N & iow_n_ff;

  assign div_en  = line_control_ff[`URS_LCR_DIV_EN_BIT];
  assign enh_key = (line_control_ff == `URS_ENH_ACCESS_KEY);
  assign enh_on  = enh_features_ff[`URS_EFR_ENH_BIT];
  assign thr_en  = enh_on & modem_control_ff[`URS_MCR_THR_EN_BIT];
  assign rdy_en  = ~CHAN_A_SEL_N & ~CHAN_B_SEL_N &
                   modem_control_ff[`URS_MCR_RDY_EN_BIT] &
                   ~modem_control_ff[`URS_MCR_LOOP_BIT];

  // ==================================================================
  // read-only views
  assign rdy_summary = {2'b00, RX_READY_IN, 2'b00, TX_READY_IN};
  // bits 7:6 both mirror the fifo enable; 5:4 visible only when enhanced
  assign irq_id = {{2{fifo_control_ff[`URS_FCR_EN_BIT]}},
                   IRQ_CODE_IN[5:4] & {2{enh_on}},
                   IRQ_CODE_IN[3:0]};
  assign modem_status = {MODEM_IN, modem_delta_ff};
  assign modem_change = MODEM_IN ^ modem_prev_ff;

  // ==================================================================
  // read decode
  always @* begin
    rd_data = 8'h00;
    case (ADDR)
      `URS_OFF_HOLDING: begin
        if (div_en) begin
          rd_data = divisor_low_ff;
        end else begin
          rd_data = RX_DATA;
        end
      end
      `URS_OFF_IRQ_ENABLE: begin
        if (div_en) begin
          rd_data = divisor_high_ff;
        end else begin
          rd_data = irq_enable_ff;
        end
      end
      `URS_OFF_IRQ_FIFO: begin
        if (enh_key) begin
          rd_data = enh_features_ff;
        end else begin
          rd_data = irq_id;
        end
      end
      `URS_OFF_LINE_CTRL: begin
        rd_data = line_control_ff;
      end
      `URS_OFF_MODEM_CTRL: begin
        if (enh_key) begin
          rd_data = resume_1_ff;
        end else begin
          rd_data = modem_control_ff;
        end
      end
      `URS_OFF_LINE_STATUS: begin
        if (enh_key) begin
          rd_data = resume_2_ff;
        end else begin
          rd_data = LINE_STATUS_IN;
        end
      end
      `URS_OFF_MODEM_STATUS: begin
        if (enh_key) begin
          rd_data = pause_1_ff;
        end else if (thr_en) begin
          rd_data = flow_thresh_ff;
        end else begin
          rd_data = modem_status;
        end
      end
      `URS_OFF_SCRATCH: begin
        if (enh_key) begin
          rd_data = pause_2_ff;
        end else if (thr_en) begin
          rd_data = trigger_lvl_ff;
        end else if (rdy_en) begin
          rd_data = rdy_summary;
        end else begin
          rd_data = scratch_ff;
        end
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // ==================================================================
  // strobe edge tracking and read data
  always @(posedge CLK) begin
    if (RESET) begin
      ior_n_ff <= 1'b1;
      iow_n_ff <= 1'b1;
      d_out_ff <= `URS_RST_BYTE;
      d_oe_ff  <= 1'b0;
    end else begin
      ior_n_ff <= IOR_N;
      iow_n_ff <= IOW_N;
      if (rd_start) begin
        d_out_ff <= rd_data;
      end
      d_oe_ff <= sel & ~IOR_N;
    end
  end

  // ==================================================================
  // modem change flags: set on input change, cleared by status read
  always @* begin
    nxt_modem_delta = modem_delta_ff;
    if (rd_start && (ADDR == `URS_OFF_MODEM_STATUS) && !enh_key && !thr_en) begin
      nxt_modem_delta = 4'h0;
    end
    // a change in the clearing cycle is kept
    nxt_modem_delta = nxt_modem_delta | modem_change;
  end

  always @(posedge CLK) begin
    if (RESET) begin
      modem_prev_ff  <= 4'h0;
      modem_delta_ff <= 4'h0;
    end else begin
      modem_prev_ff  <= MODEM_IN;
      modem_delta_ff <= nxt_modem_delta;
    end
  end

  // ==================================================================
  // side-effect pulses
  always @(posedge CLK) begin
    if (RESET) begin
      tx_data_ff  <= `URS_RST_BYTE;
      tx_write_ff <= 1'b0;
      rx_read_ff  <= 1'b0;
      rx_rst_ff   <= 1'b0;
      tx_rst_ff   <= 1'b0;
    end else begin
      tx_write_ff <= 1'b0;
      rx_read_ff  <= 1'b0;
      rx_rst_ff   <= 1'b0;
      tx_rst_ff   <= 1'b0;
      if (wr_start && (ADDR == `URS_OFF_HOLDING) && !div_en) begin
        tx_data_ff  <= D_IN;
        tx_write_ff <= 1'b1;
      end
      if (rd_start && (ADDR == `URS_OFF_HOLDING) && !div_en) begin
        rx_read_ff <= 1'b1;
      end
      if (wr_start && (ADDR == `URS_OFF_IRQ_FIFO) && !enh_key) begin
        rx_rst_ff <= D_IN[`URS_FCR_RXRST_BIT];
        tx_rst_ff <= D_IN[`URS_FCR_TXRST_BIT];
      end
    end
  end

  // ==================================================================
  // register writes
  always @(posedge CLK) begin
    if (RESET) begin
      divisor_low_ff   <= `URS_RST_BYTE;
      divisor_high_ff  <= `URS_RST_BYTE;
      irq_enable_ff    <= `URS_RST_BYTE;
      fifo_control_ff  <= `URS_RST_BYTE;
      line_control_ff  <= `URS_RST_BYTE;
      modem_control_ff <= `URS_RST_BYTE;
      enh_features_ff  <= `URS_RST_BYTE;
      resume_1_ff      <= `URS_RST_BYTE;
      resume_2_ff      <= `URS_RST_BYTE;
      pause_1_ff       <= `URS_RST_BYTE;
      pause_2_ff       <= `URS_RST_BYTE;
      flow_thresh_ff   <= `URS_RST_BYTE;
      trigger_lvl_ff   <= `URS_RST_BYTE;
      scratch_ff       <= `URS_RST_BYTE;
    end else if (wr_start) begin
      case (ADDR)
        `URS_OFF_HOLDING: begin
          if (div_en) begin
            divisor_low_ff <= D_IN;
          end
        end
        `URS_OFF_IRQ_ENABLE: begin
          if (div_en) begin
            divisor_high_ff <= D_IN;
          end else if (enh_on) begin
            irq_enable_ff <= D_IN;
          end else begin
            irq_enable_ff <= (irq_enable_ff & `URS_IER_ENH_MASK) |
                             (D_IN & ~`URS_IER_ENH_MASK);
          end
        end
        `URS_OFF_IRQ_FIFO: begin
          if (enh_key) begin
            enh_features_ff <= D_IN;
          end else if (enh_on) begin
            fifo_control_ff <= D_IN & `URS_FCR_STORE_MASK;
          end else begin
            fifo_control_ff <= (fifo_control_ff & `URS_FCR_ENH_MASK) |
                               (D_IN & `URS_FCR_STORE_MASK &
                                ~`URS_FCR_ENH_MASK);
          end
        end
        `URS_OFF_LINE_CTRL: begin
          line_control_ff <= D_IN;
        end
        `URS_OFF_MODEM_CTRL: begin
          if (enh_key) begin
            resume_1_ff <= D_IN;
          end else if (enh_on) begin
            modem_control_ff <= D_IN;
          end else begin
            modem_control_ff <= (modem_control_ff & `URS_MCR_ENH_MASK) |
                                (D_IN & ~`URS_MCR_ENH_MASK);
          end
        end
        `URS_OFF_LINE_STATUS: begin
          if (enh_key) begin
            resume_2_ff <= D_IN;
          end
        end
        `URS_OFF_MODEM_STATUS: begin
          if (enh_key) begin
            pause_1_ff <= D_IN;
          end else if (thr_en) begin
            flow_thresh_ff <= D_IN;
          end
        end
        `URS_OFF_SCRATCH: begin
          if (enh_key) begin
            pause_2_ff <= D_IN;
          end else if (thr_en) begin
            trigger_lvl_ff <= D_IN;
          end else if (!rdy_en) begin
            scratch_ff <= D_IN;
          end
        end
        default: begin
          scratch_ff <= scratch_ff;
        end
      endcase
    end
  end

  // ==================================================================
  // outputs
  assign D_OUT           = d_out_ff;
  assign D_OE            = d_oe_ff;
  assign TX_DATA         = tx_data_ff;
  assign TX_WRITE        = tx_write_ff;
  assign RX_READ         = rx_read_ff;
  assign RX_FIFO_RESET   = rx_rst_ff;
  assign TX_FIFO_RESET   = tx_rst_ff;
  assign DIVISOR         = {divisor_high_ff, divisor_low_ff};
  assign IRQ_ENABLE      = irq_enable_ff;
  // transmit trigger only takes effect while enhanced functions are on
  assign FIFO_CONTROL    = fifo_control_ff & ~({8{~enh_on}} & `URS_FCR_ENH_MASK);
  assign LINE_CONTROL    = line_control_ff;
  assign MODEM_CONTROL   = modem_control_ff;
  assign ENH_FEATURES    = enh_features_ff;
  assign RESUME_CHAR_1   = resume_1_ff;
  assign RESUME_CHAR_2   = resume_2_ff;
  assign PAUSE_CHAR_1    = pause_1_ff;
  assign PAUSE_CHAR_2    = pause_2_ff;
  assign FLOW_THRESHOLDS = flow_thresh_ff;
  assign TRIGGER_LEVELS  = trigger_lvl_ff;

endmodule // urs_register_select

//--- testbench/urs_checker.sv
// concurrent checks on the ports of the uart register select block
`timescale 1ns/10ps
module urs_checker #(
  parameter CHANNEL_B = 0
) (
  input wire        CLK,
  input wire        RESET,
  input wire        CHAN_A_SEL_N,
  input wire        CHAN_B_SEL_N,
  input wire [2:0]  ADDR,
  input wire        IOR_N,
  input wire        IOW_N,
  input wire [7:0]  D_IN,
  input wire [7:0]  D_OUT,
  input wire        D_OE,
  input wire [7:0]  RX_DATA,
  input wire [1:0]  TX_READY_IN,
  input wire [1:0]  RX_READY_IN,
  input wire [7:0]  TX_DATA,
  input wire        TX_WRITE,
  input wire        RX_READ,
  input wire        RX_FIFO_RESET,
  input wire        TX_FIFO_RESET,
  input wire [15:0] DIVISOR,
  input wire [7:0]  IRQ_ENABLE,
  input wire [7:0]  FIFO_CONTROL,
  input wire [7:0]  LINE_CONTROL,
  input wire [7:0]  MODEM_CONTROL,
  input wire [7:0]  ENH_FEATURES,
  input wire [7:0]  FLOW_THRESHOLDS
);
  // ==========
  // access start detection
  reg  ior_ff;
  reg  iow_ff;
  wire own_n = (CHANNEL_B != 0) ? CHAN_B_SEL_N : CHAN_A_SEL_N;
  wire rs    = !own_n && !IOR_N && ior_ff;
  wire ws    = !own_n && !IOW_N && iow_ff;
  wire key   = LINE_CONTROL == 8'hbf;
  wire dl    = LINE_CONTROL[7];
  wire tt    = ENH_FEATURES[4] && MODEM_CONTROL[6];

  always @(posedge CLK) begin
    ior_ff <= IOR_N;
    iow_ff <= IOW_N;
  end

  default clocking dc @(posedge CLK); endclocking
  default disable iff (RESET);

  // ==========
  // assertions
  rd_hold_a: assert property (rs && ADDR == 3'h0 && !dl |=>
    RX_READ && D_OE && D_OUT == $past(RX_DATA)) else $error("holding read wrong");
  wr_hold_a: assert property (ws && ADDR == 3'h0 && !dl |=>
    TX_WRITE && TX_DATA == $past(D_IN)) else $error("holding write wrong");
  div_low_a: assert property (ws && ADDR == 3'h0 && dl |=>
    !TX_WRITE && DIVISOR[7:0] == $past(D_IN)) else $error("divisor low wrong");
  div_high_a: assert property (ws && ADDR == 3'h1 && dl |=>
    DIVISOR[15:8] == $past(D_IN) && $stable(IRQ_ENABLE)) else $error("divisor high wrong");
  efr_key_a: assert property (ws && ADDR == 3'h2 && key |=>
    ENH_FEATURES == $past(D_IN) && !RX_FIFO_RESET) else $error("enhanced write wrong");
  thresh_wr_a: assert property (ws && ADDR == 3'h6 && !key && tt |=>
    FLOW_THRESHOLDS == $past(D_IN)) else $error("threshold write wrong");
  rdy_sum_a: assert property (rs && ADDR == 3'h7 && !key && !tt && !CHAN_A_SEL_N
    && !CHAN_B_SEL_N && MODEM_CONTROL[2] && !MODEM_CONTROL[4] |=>
    D_OUT == {2'b00, $past(RX_READY_IN), 2'b00, $past(TX_READY_IN)})
    else $error("ready summary wrong");
  enh_lock_a: assert property (!ENH_FEATURES[4] |=> $stable(IRQ_ENABLE[7:4])
    && $stable(MODEM_CONTROL[7:5])) else $error("locked bits changed");
  tx_trig_a: assert property (!ENH_FEATURES[4] |->
    FIFO_CONTROL[5:4] == 2'b00) else $error("tx trigger active while locked");
  fifo_rst_a: assert property (ws && ADDR == 3'h2 && !key && D_IN[1] |=>
    RX_FIFO_RESET ##1 !RX_FIFO_RESET) else $error("rx fifo reset pulse wrong");
  oe_follow_a: assert property (D_OE == $past(!own_n && !IOR_N))
    else $error("data enable wrong");
  tx_fifo_rst_a: assert property (ws && ADDR == 3'h2 && !key |=>
    TX_FIFO_RESET == $past(D_IN[2])) else $error("tx fifo reset pulse wrong");
  lcr_write_a: assert property (ws && ADDR == 3'h3 |=>
    LINE_CONTROL == $past(D_IN)) else $error("line control write wrong");

  // ==========
  // coverage
  hold_wr_c: cover property (ws && ADDR == 3'h0 && !dl);
  div_wr_c: cover property (ws && ADDR == 3'h1 && dl);
  both_rd_c: cover property (rs && ADDR == 3'h7 && !CHAN_B_SEL_N);
endmodule // urs_checker

//--- testbench/urs_host_model.sv
// host bus model: read and write cycles on the parallel register port
`timescale 1ns/10ps
module urs_host_model (
  input  wire       clk,
  output reg        sel_a_n,
  output reg        sel_b_n,
  output reg  [2:0] addr,
  output reg        ior_n,
  output reg        iow_n,
  output reg  [7:0] d_in,
  input  wire [7:0] d_out
);
  initial begin
    {sel_a_n, sel_b_n, ior_n, iow_n} = 4'hf;
    addr = 3'h0;
    d_in = 8'h00;
  end

  // release strobes; data bus shows garbage once no longer held
  task idle;
    begin
      {sel_a_n, sel_b_n, ior_n, iow_n} <= 4'hf;
      d_in <= ~d_in;
      @(negedge clk);
    end
  endtask

  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      sel_a_n <= 1'b0;
      addr <= a;
      d_in <= d;
      iow_n <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      idle();
    end
  endtask

  task rd(input [2:0] a, input both, output [7:0] d);
    begin
      @(posedge clk);
      sel_a_n <= 1'b0;
      sel_b_n <= ~both;
      addr <= a;
      ior_n <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      d = d_out;
      @(posedge clk);
      idle();
    end
  endtask
endmodule // urs_host_model

//--- testbench/test_uart_register_select.sv
// self-checking bench of the uart register select block
`timescale 1ns/10ps
module test_uart_register_select;
  reg         clk;
  reg         reset;
  reg  [7:0]  rx_data;
  reg  [7:0]  line_st;
  reg  [5:0]  irq_code;
  reg  [3:0]  modem_in;
  reg  [1:0]  tx_rdy;
  reg  [1:0]  rx_rdy;
  reg  [7:0]  v;
  wire        sel_a_n;
  wire        sel_b_n;
  wire        ior_n;
  wire        iow_n;
  wire [2:0]  addr;
  wire [7:0]  d_in;
  wire [7:0]  d_out;
  wire [7:0]  tx_data;
  wire [7:0]  fifo_ctl;
  wire [15:0] divisor;
  wire [7:0]  ier_o;
  wire [7:0]  lcr_o;
  wire [7:0]  mcr_o;
  wire [7:0]  res1;
  wire [7:0]  res2;
  wire [7:0]  pau1;
  wire [7:0]  pau2;
  wire [7:0]  trig;
  integer     fails;
  integer     tests_run;
  integer     i;

  urs_register_select #(.CHANNEL_B(0)) DUT (
    .CLK(clk), .RESET(reset), .CHAN_A_SEL_N(sel_a_n), .CHAN_B_SEL_N(sel_b_n),
    .ADDR(addr), .IOR_N(ior_n), .IOW_N(iow_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(),
    .RX_DATA(rx_data), .LINE_STATUS_IN(line_st), .IRQ_CODE_IN(irq_code),
    .MODEM_IN(modem_in), .TX_READY_IN(tx_rdy), .RX_READY_IN(rx_rdy),
    .TX_DATA(tx_data), .TX_WRITE(), .RX_READ(), .RX_FIFO_RESET(), .TX_FIFO_RESET(),
    .DIVISOR(divisor), .IRQ_ENABLE(ier_o), .FIFO_CONTROL(fifo_ctl), .LINE_CONTROL(lcr_o),
    .MODEM_CONTROL(mcr_o), .ENH_FEATURES(), .RESUME_CHAR_1(res1), .RESUME_CHAR_2(res2),
    .PAUSE_CHAR_1(pau1), .PAUSE_CHAR_2(pau2), .FLOW_THRESHOLDS(), .TRIGGER_LEVELS(trig)
  );

  urs_host_model u_host (
    .clk(clk), .sel_a_n(sel_a_n), .sel_b_n(sel_b_n), .addr(addr),
    .ior_n(ior_n), .iow_n(iow_n), .d_in(d_in), .d_out(d_out)
  );

  // ==========
  // check helpers
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task rdc(input [2:0] a, input both, input [7:0] exp, input string nm);
    begin
      u_host.rd(a, both, v);
      chk(nm, {8'h00, exp}, {8'h00, v});
    end
  endtask

  task end_sim;
    begin
      if (fails == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    chk("timeout", 16'h0001, 16'h0000);
    end_sim;
  end

  // ==========
  // main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    reset = 1'b1;
    rx_data = 8'h5a;
    line_st = 8'h61;
    irq_code = 6'h3d;
    modem_in = 4'h0;
    tx_rdy = 2'b10;
    rx_rdy = 2'b01;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    rdc(3'h3, 1'b0, 8'h00, "lcr_rst");
    rdc(3'h1, 1'b0, 8'h00, "ier_rst");
    rdc(3'h0, 1'b0, 8'h5a, "rx_hold");
    rdc(3'h5, 1'b0, 8'h61, "lsr");
    rdc(3'h2, 1'b0, 8'h0d, "iir");
    rdc(3'h6, 1'b0, 8'h00, "msr");
    u_host.wr(3'h0, 8'h77);
    chk("tx_data", 16'h0077, {8'h00, tx_data});
    u_host.wr(3'h1, 8'hff);
    rdc(3'h1, 1'b0, 8'h0f, "ier_lock");
    u_host.wr(3'h4, 8'hff);
    rdc(3'h4, 1'b0, 8'h1f, "mcr_lock");
    u_host.wr(3'h7, 8'h3c);
    rdc(3'h7, 1'b0, 8'h3c, "scratch");
    u_host.wr(3'h2, 8'hf7);
    chk("fcr_lock", 16'h00c1, {8'h00, fifo_ctl});
    rdc(3'h2, 1'b0, 8'hcd, "iir_fifo");
    u_host.wr(3'h3, 8'h80);
    u_host.wr(3'h0, 8'h34);
    u_host.wr(3'h1, 8'h12);
    chk("divisor", 16'h1234, divisor);
    rdc(3'h1, 1'b0, 8'h12, "div_high");
    rdc(3'h0, 1'b0, 8'h34, "div_low");
    u_host.wr(3'h3, 8'hbf);
    u_host.wr(3'h2, 8'h10);
    for (i = 4; i < 8; i = i + 1) u_host.wr(i[2:0], 8'h11 * i[7:0]);
    chk("resume_1", 16'h0044, {8'h00, res1});
    chk("resume_2", 16'h0055, {8'h00, res2});
    chk("pause_1", 16'h0066, {8'h00, pau1});
    chk("pause_2", 16'h0077, {8'h00, pau2});
    for (i = 4; i < 8; i = i + 1) rdc(i[2:0], 1'b0, 8'h11 * i[7:0], "flow_char");
    rdc(3'h2, 1'b0, 8'h10, "efr");
    rdc(3'h3, 1'b0, 8'hbf, "lcr_key");
    u_host.wr(3'h3, 8'h03);
    chk("lcr_out", 16'h0003, {8'h00, lcr_o});
    rdc(3'h1, 1'b0, 8'h0f, "ier_keep");
    rdc(3'h7, 1'b0, 8'h3c, "scratch_keep");
    u_host.wr(3'h1, 8'hff);
    rdc(3'h1, 1'b0, 8'hff, "ier_open");
    chk("ier_out", 16'h00ff, {8'h00, ier_o});
    u_host.wr(3'h4, 8'he4);
    rdc(3'h4, 1'b0, 8'he4, "mcr_open");
    chk("mcr_out", 16'h00e4, {8'h00, mcr_o});
    u_host.wr(3'h6, 8'h5a);
    u_host.wr(3'h7, 8'ha5);
    chk("trig_out", 16'h00a5, {8'h00, trig});
    rdc(3'h6, 1'b0, 8'h5a, "thresholds");
    rdc(3'h7, 1'b1, 8'ha5, "trig_levels");
    u_host.wr(3'h4, 8'ha4);
    rdc(3'h7, 1'b1, 8'h12, "fifo_ready");
    rdc(3'h7, 1'b0, 8'h3c, "scratch_own");
    rdc(3'h6, 1'b0, 8'h00, "msr_view");
    u_host.wr(3'h2, 8'h31);
    chk("fcr_open", 16'h0031, {8'h00, fifo_ctl});
    rdc(3'h2, 1'b0, 8'hfd, "iir_open");
    @(posedge clk) modem_in <= 4'h5;
    rdc(3'h6, 1'b0, 8'h55, "msr_delta");
    rdc(3'h6, 1'b0, 8'h50, "msr_clear");
    end_sim;
  end
endmodule // test_uart_register_select

bind urs_register_select urs_checker #(.CHANNEL_B(CHANNEL_B)) u_chk (
  .CLK(CLK), .RESET(RESET), .CHAN_A_SEL_N(CHAN_A_SEL_N), .CHAN_B_SEL_N(CHAN_B_SEL_N),
  .ADDR(ADDR), .IOR_N(IOR_N), .IOW_N(IOW_N), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE(D_OE),
  .RX_DATA(RX_DATA), .TX_READY_IN(TX_READY_IN), .RX_READY_IN(RX_READY_IN),
  .TX_DATA(TX_DATA), .TX_WRITE(TX_WRITE), .RX_READ(RX_READ),
  .RX_FIFO_RESET(RX_FIFO_RESET), .TX_FIFO_RESET(TX_FIFO_RESET),
  .DIVISOR(DIVISOR), .IRQ_ENABLE(IRQ_ENABLE),
  .FIFO_CONTROL(FIFO_CONTROL), .LINE_CONTROL(LINE_CONTROL),
  .MODEM_CONTROL(MODEM_CONTROL), .ENH_FEATURES(ENH_FEATURES),
  .FLOW_THRESHOLDS(FLOW_THRESHOLDS)
);
